/* src/fls_pkg.sv */
// Package of constants and types for the frequency list step sequencer.
package fls_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned LIST_COUNT   = 4;
  localparam int unsigned STEP_COUNT   = 16;
  localparam int unsigned LIST_BITS    = 2;
  localparam int unsigned STEP_BITS    = 4;
  localparam int unsigned PHASE_BITS   = 32;
  localparam int unsigned LUT_ADDR_BITS = 16;
  localparam int unsigned SAMPLE_BITS  = 16;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_CMD      = 12'h004;
  localparam logic [11:0] REG_STATUS   = 12'h008;
  localparam logic [11:0] REG_AMPL     = 12'h00C;
  localparam logic [11:0] REG_OFFSET   = 12'h010;
  localparam logic [11:0] REG_PHASE    = 12'h014;
  localparam logic [11:0] REG_MAXLIST  = 12'h018;
  localparam logic [11:0] REG_STEP_IDX = 12'h01C;
  localparam logic [11:0] REG_STEP_FRQ = 12'h020;
  localparam logic [11:0] REG_STEP_DUR = 12'h024;
  localparam logic [11:0] REG_LUT_ADDR = 12'h028;
  localparam logic [11:0] REG_LUT_DATA = 12'h02C;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SRC_BIT  = 2;
  localparam int unsigned CTRL_LIST_LSB = 4;
  localparam int unsigned CMD_INIT_BIT  = 0;
  localparam int unsigned CMD_ABORT_BIT = 1;
  localparam int unsigned CMD_SWTRG_BIT = 2;
  localparam int unsigned IDX_LIST_LSB  = 4;

  // ==========================================================================
  // Reset values and response codes
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0004;
  localparam logic [31:0] ZERO_RESET   = 32'h0000_0000;
  localparam logic [15:0] AMPL_RESET   = 16'hFFFF;
  localparam logic [15:0] OFFSET_RESET = 16'h8000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {TM_SINGLE, TM_CONTINUOUS, TM_STEPPED, TM_BURST} fls_mode_t;
  typedef enum {ST_IDLE, ST_ARMED, ST_RUN, ST_HOLD_WAVE, ST_HOLD_DC} fls_state_t;

endpackage

/* src/fls_sequencer.sv */
// Frequency list step sequencer with AXI4-Lite register access.
`timescale 1ns/1ps

// What this block does
// - Each step holds a frequency and duration.
// - All steps share one lookup waveform.
// - Several lists stored; only active plays.
// - Amplitude, offset, phase apply to active list.
// - Single mode stops at DC after last.
// - Single mode ignores triggers after first.
// - Continuous mode advances and wraps until abort.
// - Continuous mode ignores triggers after first.
// - Stepped mode holds DC until next trigger.
// - Stepped mode trigger starts next step.
// - Stepped mode wraps to first step.
// - Burst keeps waveform until next trigger.
// - Stepped and burst defer first trigger during duration.
// - Further triggers during duration are dropped.
// - Immediate source advances only on software trigger.
// - External trigger rising edge only, after initiate.
// - Immediate source self-triggers after initiate.
// - Abort leaves output at DC offset.
module fls_sequencer
  import fls_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   ext_trigger,
  output logic [SAMPLE_BITS-1:0]      sample_out,
  output logic                        generating
);

  // ==========================================================================
  // Registers and storage
  logic [31:0]            ctrl_q;
  logic [15:0]            ampl_q;
  logic [15:0]            offset_q;
  logic [PHASE_BITS-1:0]  phase_q;
  logic [31:0]            step_idx_q;
  logic [31:0]            lut_addr_q;
  logic [PHASE_BITS-1:0]  freq_mem_q [LIST_COUNT*STEP_COUNT];
  logic [31:0]            dur_mem_q  [LIST_COUNT*STEP_COUNT];
  logic [STEP_BITS-1:0]   last_mem_q [LIST_COUNT];
  logic [SAMPLE_BITS-1:0] lut_q      [2**8];
  fls_state_t             state_q;
  logic [STEP_BITS-1:0]   step_q;
  logic [31:0]            dur_cnt_q;
  logic                   pend_q;
  logic                   first_q;
  logic [PHASE_BITS-1:0]  acc_q;
  logic                   ext_s1_q;
  logic                   ext_s2_q;
  logic                   ext_s3_q;
  logic                   aw_q;
  logic                   w_q;
  logic [11:0]            awaddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   cmd_init;
  logic                   cmd_abort;
  logic                   cmd_swtrg;
  logic                   wr_go;
  logic                   trig;
  logic                   expire;
  logic [STEP_BITS-1:0]   next_step;
  logic                   wrap;

  fls_mode_t              mode;
  logic                   src_imm;
  logic [LIST_BITS-1:0]   active_list_select;

  assign mode               = fls_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign src_imm            = ctrl_q[CTRL_SRC_BIT];
  assign active_list_select = ctrl_q[CTRL_LIST_LSB +: LIST_BITS];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [LIST_BITS+STEP_BITS-1:0] slot(input logic [LIST_BITS-1:0] l,
                                                          input logic [STEP_BITS-1:0] s);
    return {l, s};
  endfunction

  // ==========================================================================
  // AXI4-Lite write channel
  assign wr_go = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q <= REG_LUT_DATA && awaddr_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign cmd_init  = wr_go && awaddr_q == REG_CMD && wstrb_q[0] && wdata_q[CMD_INIT_BIT];
  assign cmd_abort = wr_go && awaddr_q == REG_CMD && wstrb_q[0] && wdata_q[CMD_ABORT_BIT];
  assign cmd_swtrg = wr_go && awaddr_q == REG_CMD && wstrb_q[0] && wdata_q[CMD_SWTRG_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= CTRL_RESET;
      ampl_q     <= AMPL_RESET;
      offset_q   <= OFFSET_RESET;
      phase_q    <= ZERO_RESET;
      step_idx_q <= ZERO_RESET;
      lut_addr_q <= ZERO_RESET;
    end else if (wr_go) begin
      case (awaddr_q)
        REG_CTRL:     ctrl_q     <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0037;
        REG_AMPL:     ampl_q     <= 16'(merge({16'h0000, ampl_q}, wdata_q, wstrb_q));
        REG_OFFSET:   offset_q   <= 16'(merge({16'h0000, offset_q}, wdata_q, wstrb_q));
        REG_PHASE:    phase_q    <= merge(phase_q, wdata_q, wstrb_q);
        REG_STEP_IDX: step_idx_q <= merge(step_idx_q, wdata_q, wstrb_q) & 32'h0000_003F;
        REG_LUT_ADDR: lut_addr_q <= merge(lut_addr_q, wdata_q, wstrb_q) & 32'h0000_00FF;
        default: begin
        end
      endcase
    end
  end

  // Step table, last step index of each list and waveform memory.
  always_ff @(posedge aclk) begin
    if (wr_go && awaddr_q == REG_STEP_FRQ) begin
      freq_mem_q[step_idx_q[5:0]] <= wdata_q;
    end
    if (wr_go && awaddr_q == REG_STEP_DUR) begin
      dur_mem_q[step_idx_q[5:0]] <= wdata_q;
    end
    if (wr_go && awaddr_q == REG_MAXLIST) begin
      last_mem_q[step_idx_q[IDX_LIST_LSB +: LIST_BITS]] <= wdata_q[STEP_BITS-1:0];
    end
    if (wr_go && awaddr_q == REG_LUT_DATA) begin
      lut_q[lut_addr_q[7:0]] <= wdata_q[SAMPLE_BITS-1:0];
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          REG_CTRL:     s_axi_rdata <= ctrl_q;
          REG_CMD:      s_axi_rdata <= 32'h0000_0000;
          REG_STATUS:   s_axi_rdata <= {20'h00000, step_q, 3'h0, pend_q, 1'b0, 3'(state_q)};
          REG_AMPL:     s_axi_rdata <= {16'h0000, ampl_q};
          REG_OFFSET:   s_axi_rdata <= {16'h0000, offset_q};
          REG_PHASE:    s_axi_rdata <= phase_q;
          REG_MAXLIST:  s_axi_rdata <= 32'(LIST_COUNT);
          REG_STEP_IDX: s_axi_rdata <= step_idx_q;
          REG_STEP_FRQ: s_axi_rdata <= freq_mem_q[step_idx_q[5:0]];
          REG_STEP_DUR: s_axi_rdata <= dur_mem_q[step_idx_q[5:0]];
          REG_LUT_ADDR: s_axi_rdata <= lut_addr_q;
          REG_LUT_DATA: s_axi_rdata <= {16'h0000, lut_q[lut_addr_q[7:0]]};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Trigger input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_trigger;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // External edges count only with the external source; software always counts.
  assign trig = (!src_imm && ext_s2_q && !ext_s3_q) || cmd_swtrg;

  // ==========================================================================
  // Step sequencer
  assign expire    = (state_q == ST_RUN) && (dur_cnt_q == 32'h0000_0000);
  assign wrap      = (step_q == last_mem_q[active_list_select]);
  assign next_step = wrap ? '0 : step_q + 1'b1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q   <= ST_IDLE;
      step_q    <= '0;
      dur_cnt_q <= 32'h0000_0000;
      pend_q    <= 1'b0;
      first_q   <= 1'b0;
    end else if (cmd_abort) begin
      state_q <= ST_IDLE;
      pend_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_init) begin
            state_q <= ST_ARMED;
            step_q  <= '0;
            first_q <= 1'b1;
            pend_q  <= 1'b0;
          end
        end
        ST_ARMED: begin
          if (trig || src_imm) begin
            state_q   <= ST_RUN;
            dur_cnt_q <= dur_mem_q[slot(active_list_select, step_q)];
            first_q   <= 1'b0;
          end
        end
        ST_RUN: begin
          if (!expire) begin
            dur_cnt_q <= dur_cnt_q - 32'h0000_0001;
            if (trig && !pend_q && (mode == TM_STEPPED || mode == TM_BURST)) begin
              pend_q <= 1'b1;
            end
          end else begin
            case (mode)
              TM_SINGLE: begin
                if (wrap) begin
                  state_q <= ST_HOLD_DC;
                end else begin
                  step_q    <= next_step;
                  dur_cnt_q <= dur_mem_q[slot(active_list_select, next_step)];
                end
              end
              TM_CONTINUOUS: begin
                step_q    <= next_step;
                dur_cnt_q <= dur_mem_q[slot(active_list_select, next_step)];
              end
              default: begin
                if (pend_q || trig) begin
                  step_q    <= next_step;
                  dur_cnt_q <= dur_mem_q[slot(active_list_select, next_step)];
                  pend_q    <= 1'b0;
                end else begin
                  state_q <= (mode == TM_STEPPED) ? ST_HOLD_DC : ST_HOLD_WAVE;
                end
              end
            endcase
          end
        end
        ST_HOLD_WAVE, ST_HOLD_DC: begin
          if (trig && state_q == ST_HOLD_DC && mode != TM_STEPPED) begin
            state_q <= ST_HOLD_DC;
          end else if (trig) begin
            state_q   <= ST_RUN;
            step_q    <= next_step;
            dur_cnt_q <= dur_mem_q[slot(active_list_select, next_step)];
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Waveform synthesis
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q      <= '0;
      sample_out <= OFFSET_RESET;
      generating <= 1'b0;
    end else begin
      generating <= (state_q == ST_RUN) || (state_q == ST_HOLD_WAVE);
      if (state_q == ST_RUN || state_q == ST_HOLD_WAVE) begin
        acc_q      <= acc_q + freq_mem_q[slot(active_list_select, step_q)];
        sample_out <= 16'(offset_q +
                          16'((32'(lut_q[acc_q[PHASE_BITS-1 -: 8]]) * ampl_q) >> 16) - (ampl_q >> 1));
      end else begin
        acc_q      <= phase_q;
        sample_out <= offset_q;
      end
    end
  end

endmodule

/* test/fls_trig_src.sv */
// Model of the external start trigger source.
`timescale 1ns/1ps
module fls_trig_src #(
  parameter int PULSE_CYC = 3
) (
  input  wire logic aclk,
  input  wire logic fire,
  output logic      ext_trigger
);
  int cnt_q = 0;

  // ==========================================================================
  // Pulse generation
  // A request gives one clean rising edge, then the line rests low.
  always @(posedge aclk) begin
    if (fire) begin
      cnt_q <= PULSE_CYC;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign ext_trigger = (cnt_q != 0);
endmodule

/* test/fls_sequencer_chk.sv */
// Checker of the sequencer port behaviour.
`timescale 1ns/1ps
module fls_sequencer_chk
  import fls_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        generating
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Sequences
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence abort_taken;
    wr_taken ##0 (s_axi_awaddr == REG_CMD && s_axi_wdata[CMD_ABORT_BIT]);
  endsequence

  // ==========================================================================
  // Assertions
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response changed early");
  a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_abort_stops: assert property (abort_taken |-> ##[1:4] !generating)
    else $error("abort did not stop generation");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !generating && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
endmodule

bind fls_sequencer fls_sequencer_chk chk_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .generating(generating)
);

/* test/frequency_list_step_sequencer_test.sv */
// Self-checking testbench of the sequencer.
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module frequency_list_step_sequencer_test;
  import fls_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, fire = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ext_trigger, generating;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rdv, seed = 32'hB05E7016;
  logic [1:0]  bresp, rresp, rsp, wrsp;
  logic [15:0] sample_out, offs;
  int          errors = 0, n_checks = 0, c;
  int          dur[4];
  int          seen[$];

  fls_sequencer fls_sequencer_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_trigger(ext_trigger), .sample_out(sample_out), .generating(generating)
  );
  fls_trig_src fls_trig_src_inst (.aclk(aclk), .fire(fire), .ext_trigger(ext_trigger));

  // ==========================================================================
  // Helpers
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wrsp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic pulse();
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_gen(input logic lvl, output int n);
    n = 0;
    while (generating !== lvl && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    if (generating !== lvl) begin
      errors++;
      $display("mismatch generating expected %0d seen %0d", lvl, generating);
      wrap_up();
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    cyc(30000);
    errors++;
    wrap_up();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    cyc(16);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(REG_CTRL, rdv, rsp);
    `CHK("ctrl reset", CTRL_RESET, rdv);
    rd(REG_MAXLIST, rdv, rsp);
    `CHK("list count", LIST_COUNT, rdv);
    rd(12'h100, rdv, rsp);
    `CHK("unmapped resp", RESP_SLVERR, rsp);
    `CHK("unmapped data", 0, rdv);
    wr(12'h102, 32'h1);
    `CHK("unaligned resp", RESP_SLVERR, wrsp);
    wr(REG_LUT_ADDR, 32'h0000_0005);
    c = int'(xs() & 32'h0000_FFFF);
    wr(REG_LUT_DATA, 32'(c));
    rd(REG_LUT_DATA, rdv, rsp);
    `CHK("lut readback", c, rdv);
    offs = 16'(xs());
    wr(REG_OFFSET, 32'(offs));
    wr(REG_AMPL, xs());
    wr(REG_PHASE, xs());
    for (int i = 0; i < 4; i++) begin
      dur[i] = (i == 3) ? 20 : 30 + int'(xs() & 32'h7);
      wr(REG_STEP_IDX, 32'(i == 3 ? 16 : i));
      wr(REG_STEP_FRQ, xs());
      wr(REG_STEP_DUR, 32'(dur[i]));
    end
    wr(REG_MAXLIST, 32'h0);
    wr(REG_STEP_IDX, 32'h0);
    wr(REG_MAXLIST, 32'h2);
    $display("test registers done");
    wr(REG_CTRL, 32'h14);
    wr(REG_CMD, 32'h1);
    wait_gen(1'b1, c);
    wait_gen(1'b0, c);
    `CHK("single length", 1, c >= dur[3] - 4 && c <= dur[3] + 3);
    `CHK("single rest level", offs, sample_out);
    wr(REG_CMD, 32'h4);
    cyc(10);
    `CHK("single retrigger", 0, generating);
    $display("test single done");
    wr(REG_CMD, 32'h2);
    wr(REG_CTRL, 32'h05);
    wr(REG_CMD, 32'h1);
    wr(REG_CMD, 32'h4);
    seen = {};
    for (int k = 0; k < 300 && seen.size() < 5; k++) begin
      rd(REG_STATUS, rdv, rsp);
      if (seen.size() == 0 || seen[$] != int'(rdv[11:8])) seen.push_back(int'(rdv[11:8]));
    end
    for (int k = 0; k < 5; k++) `CHK("cont step", k % 3, seen[k]);
    `CHK("cont running", 1, generating);
    wr(REG_CMD, 32'h2);
    cyc(5);
    `CHK("abort gen", 0, generating);
    `CHK("abort level", offs, sample_out);
    $display("test continuous done");
    wr(REG_CTRL, 32'h02);
    pulse();
    cyc(10);
    `CHK("trigger before init", 0, generating);
    wr(REG_CMD, 32'h1);
    cyc(10);
    `CHK("no self trigger", 0, generating);
    pulse();
    wait_gen(1'b1, c);
    rd(REG_STATUS, rdv, rsp);
    `CHK("stepped first", 0, rdv[11:8]);
    pulse();
    cyc(6);
    pulse();
    cyc(dur[0]);
    rd(REG_STATUS, rdv, rsp);
    `CHK("held trigger step", 1, rdv[11:8]);
    `CHK("held trigger gen", 1, generating);
    cyc(dur[1] + 10);
    `CHK("extra trigger dropped", 0, generating);
    `CHK("stepped rest level", offs, sample_out);
    pulse();
    wait_gen(1'b1, c);
    wait_gen(1'b0, c);
    pulse();
    wait_gen(1'b1, c);
    rd(REG_STATUS, rdv, rsp);
    `CHK("stepped wrap", 0, rdv[11:8]);
    $display("test stepped done");
    wr(REG_CMD, 32'h2);
    wr(REG_CTRL, 32'h07);
    wr(REG_CMD, 32'h1);
    wait_gen(1'b1, c);
    `CHK("immediate start", 1, generating);
    cyc(dur[0] + 20);
    pulse();
    cyc(10);
    rd(REG_STATUS, rdv, rsp);
    `CHK("burst hold step", 0, rdv[11:8]);
    `CHK("burst hold gen", 1, generating);
    wr(REG_CMD, 32'h4);
    cyc(5);
    rd(REG_STATUS, rdv, rsp);
    `CHK("burst soft advance", 1, rdv[11:8]);
    wr(REG_CMD, 32'h2);
    $display("test burst done");
    wrap_up();
  end
endmodule
